// ---- ocp_phase_overcurrent.sv ----
// Purpose: Three-phase non-directional overcurrent element
// Assumes: Currents in hundredths of rated current, same clock
// Notes:   Registers on AXI4-Lite; all delays count 1 ms ticks
// Operation
// [R01] Fault when any one or more phases exceed the pickup level.
// [R02] Each phase current is compared on its own input.
// [R03] One settings set, separate pickup and trip per phase.
// [R04] Disabled element gives no pickup and no trip.
// [R05] Modes: instantaneous, fixed delay, seven standard curves plus one.
// [R06] Instantaneous mode trips exactly like fixed delay mode.
// [R07] Independent instances each hold their own settings.
// [R08] Pickup level 0.05 to 40.00 times rated, default 1.00.
// [R09] Trip delay 0.00 to 300.00 s, default 0.50 s.
// [R10] Pickup confirmation delay 0 to 1000 ms, default 5.
// [R11] Drop-out delay 0 to 60 s, default 0.20, pickup held; after a trip the code drops pickup at once, no delay.
// [R12] Drop-out ratio 0.80 to 1.00, default 0.95, sets drop level.
// [R13] Curve multiplier 0.05 to 1.00 scales inverse trip time.
// [R14] Inrush blocking source is none or one of two detectors.
// [R15] Pickup block source is none or one of four variables.
// [R16] Cold-load boost starts on its input or 5 % after idle.
// [R17] Boost multiplies pickup and drop levels by 1.01 to 10.00.
// [R18] Boost lasts 0 to 3600 s, default 60, then ends.
// [R19] Boost is shared and leaves inverse timing unchanged.
// [R20] Count pickup events and trip events.
// [R21] Count pickup events per phase.
// [R22] Count each cold-load boost activation.
// [R23] Pickup needs fault, expired confirmation and no blocking.
// [R24] Trip needs fault, pickup, expired delay, no blocking.
// [R25] Blocking drops pickup, flags blocked, resets trip timer.
// [R26] Inverse mode integrates curve rate, ratio clamped 1.1 to 20.
// [R27] Timers count a 1 ms tick enable from the clock.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defines.svh"
module ocp_phase_overcurrent
  import ocp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `OCP_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] phaseACurrent,
  input  wire logic [15:0] phaseBCurrent,
  input  wire logic [15:0] phaseCCurrent,
  input  wire logic [1:0]  inrushDetect,
  input  wire logic [3:0]  blockVariable,
  input  wire logic        coldLoadInput,
  output logic [2:0]       pickup,
  output logic [2:0]       trip,
  output logic [2:0]       pickupBlocked,
  output logic             coldLoadActive
);
  localparam int DW = $clog2(TICK_CYCLES);
  localparam logic [31:0] CFG_RST [`OCP_NCFG] = '{
    `OCP_RV_CTRL, `OCP_RV_THR, `OCP_RV_TRIPDLY, `OCP_RV_PICKDLY, `OCP_RV_DROPDLY,
    `OCP_RV_RATIO, `OCP_RV_TMS, `OCP_RV_CLBLVL, `OCP_RV_CLBDUR, `OCP_RV_CLBIDLE};
  localparam logic [31:0] CFG_MSK [`OCP_NCFG] = '{
    `OCP_MK_CTRL, 32'h0000_0fff, 32'h0000_7fff, 32'h0000_03ff, 32'h0000_1fff,
    32'h0000_007f, 32'h0000_007f, 32'h0000_03ff, 32'h0000_0fff, 32'h0000_0fff};

  // ******
  // Millisecond tick
  // ******
  logic [DW-1:0] divCnt;
  logic          tick;
  wire           divWrap = divCnt == DW'(TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt <= '0;
      tick   <= 1'b0;
    end else begin
      divCnt <= divWrap ? '0 : divCnt + 1'b1;
      tick   <= divWrap; // [R27]
    end
  end

  // ******
  // Register bus
  // ******
  logic [31:0] cfg [`OCP_NCFG];
  logic [15:0] cnt [`OCP_NCNT];
  logic [31:0] statusWord;

  wire        wrGo    = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire [5:0]  wIdx    = s_axi_awaddr[7:2];
  wire        wCfgHit = wIdx < 6'(`OCP_NCFG);
  wire        wClrHit = wIdx == `OCP_A_CNTCLR;
  wire [31:0] wMask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire        cntClr  = wrGo && wClrHit;
  wire        rdGo    = s_axi_arvalid && !s_axi_rvalid;
  wire [5:0]  rIdx    = s_axi_araddr[7:2];
  wire        rCnt    = rIdx >= `OCP_A_CNT0 && rIdx < `OCP_A_CNT0 + 6'(`OCP_NCNT);
  wire [5:0]  rCntIdx = rIdx - `OCP_A_CNT0;
  wire        rHit    = rIdx < 6'(`OCP_NCFG) || rIdx == `OCP_A_STATUS || rCnt;
  wire [31:0] rVal    = rIdx < 6'(`OCP_NCFG) ? cfg[rIdx[3:0]] :
                        rIdx == `OCP_A_STATUS ? statusWord :
                        rCnt ? {16'h0000, cnt[rCntIdx[2:0]]} : 32'h0000_0000;

  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;
  assign s_axi_arready = rdGo;

  for (genvar i = 0; i < `OCP_NCFG; i++) begin : g_cfg
    wire [31:0] m = wMask & CFG_MSK[i];
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cfg[i] <= CFG_RST[i];
      end else if (wrGo && wIdx == 6'(i)) begin
        cfg[i] <= (cfg[i] & ~m) | (s_axi_wdata & m); // [R07]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OCP_RESP_OK;
    end else if (wrGo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wCfgHit || wClrHit) ? `OCP_RESP_OK : `OCP_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `OCP_RESP_OK;
    end else if (rdGo) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rVal;
      s_axi_rresp  <= rHit ? `OCP_RESP_OK : `OCP_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ******
  // Settings
  // ******
  wire        enable   = cfg[`OCP_R_CTRL][`OCP_F_EN];
  wire [3:0]  modeRaw  = cfg[`OCP_R_CTRL][`OCP_F_MODE];
  wire [1:0]  inSel    = cfg[`OCP_R_CTRL][`OCP_F_INRUSH];
  wire [2:0]  blkSel   = cfg[`OCP_R_CTRL][`OCP_F_BLOCK];
  wire        clbEn    = cfg[`OCP_R_CTRL][`OCP_F_CLBEN];
  wire [11:0] thr      = cfg[`OCP_R_THR][11:0];      // [R08]
  wire [14:0] tripDly  = cfg[`OCP_R_TRIPDLY][14:0];  // [R09]
  wire [9:0]  pickDly  = cfg[`OCP_R_PICKDLY][9:0];   // [R10]
  wire [12:0] dropDly  = cfg[`OCP_R_DROPDLY][12:0];  // [R11]
  wire [6:0]  ratio    = cfg[`OCP_R_RATIO][6:0];     // [R12]
  wire [6:0]  tms      = cfg[`OCP_R_TMS][6:0];       // [R13]
  wire [9:0]  clbLvl   = cfg[`OCP_R_CLBLVL][9:0];
  wire [11:0] clbDur   = cfg[`OCP_R_CLBDUR][11:0];
  wire [11:0] clbIdle  = cfg[`OCP_R_CLBIDLE][11:0];

  // Unknown mode codes fall back to fixed delay
  wire        modeBad  = modeRaw > OCP_RI_CURVE;
  wire        inverse  = !modeBad && modeRaw >= OCP_IEC_NI; // [R05] [R06]
  wire [3:0]  curveIdx = modeRaw - OCP_IEC_NI;

  // ******
  // Blocking sources
  // ******
  wire [3:0]  inrushVec = {1'b0, inrushDetect, 1'b0};
  wire [7:0]  varVec    = {3'b000, blockVariable, 1'b0};
  wire        blockAct  = inrushVec[inSel] || varVec[blkSel]; // [R14] [R15]

  // ******
  // Cold-load boost
  // ******
  logic        clSync1;
  logic        clSync2;
  logic        clPrev;
  logic [21:0] idleMs;
  logic [21:0] clbMs;
  logic        clbAct;
  logic [15:0] cur [3];

  assign cur[0] = phaseACurrent;
  assign cur[1] = phaseBCurrent;
  assign cur[2] = phaseCCurrent;

  wire        lowAll   = cur[0] < `OCP_CLB_MIN && cur[1] < `OCP_CLB_MIN &&
                         cur[2] < `OCP_CLB_MIN;
  wire [21:0] idleLim  = 22'(clbIdle) * `OCP_MS_PER_S;
  wire [21:0] durLim   = 22'(clbDur) * `OCP_MS_PER_S;
  wire        idleDone = idleMs >= idleLim;
  wire        clbStart = clbEn && !clbAct &&
                         ((clSync2 && !clPrev) || (idleDone && !lowAll)); // [R16]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clSync1 <= 1'b0;
      clSync2 <= 1'b0;
      clPrev  <= 1'b0;
    end else begin
      clSync1 <= coldLoadInput;
      clSync2 <= clSync1;
      clPrev  <= clSync2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idleMs <= '0;
    end else if (!lowAll || clbAct) begin
      idleMs <= '0;
    end else if (tick && !idleDone) begin
      idleMs <= idleMs + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clbAct <= 1'b0;
      clbMs  <= '0;
    end else if (clbStart) begin
      clbAct <= 1'b1;
      clbMs  <= '0;
    end else if (!clbEn || clbMs >= durLim) begin
      clbAct <= 1'b0; // [R18]
    end else if (clbAct && tick) begin
      clbMs  <= clbMs + 1'b1;
    end
  end

  assign coldLoadActive = clbAct; // [R19]

  // ******
  // Levels
  // ******
  wire [9:0]  lvlEff  = clbAct ? clbLvl : `OCP_UNITY;
  wire [21:0] pickRef = 22'(thr) * 22'(lvlEff); // [R17]
  wire [28:0] dropRef = 29'(pickRef) * 29'(ratio);
  wire [22:0] thrX2   = 23'(thr) * 23'd200;
  wire [22:0] thrX5   = 23'(thr) * 23'd500;
  wire [22:0] thrX10  = 23'(thr) * 23'd1000;
  wire [22:0] thrX20  = 23'(thr) * 23'd2000;
  wire [16:0] dropLim = 17'(dropDly) * `OCP_MS_PER_10MS;
  wire [31:0] dtLim   = 32'(tripDly) * 32'(`OCP_MS_PER_10MS);
  wire [38:0] invLim  = 39'(tms) << `OCP_TMS_SHIFT;

  ocp_curve_if cvIf ();

  ocp_curve_rom u_rom (
    .clk   (clk),
    .rst_n (rst_n),
    .cv    (cvIf.lookup)
  );

  assign cvIf.curve = curveIdx[2:0];

  // ******
  // Per-phase pickup and trip
  // ******
  ocp_state_e st [3];
  logic [2:0] faultVec;
  logic [2:0] next_pick;
  logic [2:0] next_trip;

  for (genvar p = 0; p < 3; p++) begin : g_ph
    ocp_state_e  next_st;
    logic [9:0]  pdCnt;
    logic [9:0]  next_pd;
    logic [16:0] ddCnt;
    logic [16:0] next_dd;
    logic [31:0] tmr;
    logic [31:0] next_tmr;

    wire [22:0] curX100 = 23'(cur[p]) * 23'd100;
    wire [29:0] curX1e4 = 30'(cur[p]) * 30'd10000;
    wire        fault   = enable && curX100 > 23'(pickRef); // [R01] [R02] [R04]
    wire        below   = curX1e4 < 30'(dropRef);           // [R12] [R17]
    wire        dtDone  = tmr >= dtLim;
    wire        invDone = 39'(tmr) * 39'd100 >= invLim;     // [R13]
    wire        expired = inverse ? invDone : dtDone;
    wire [31:0] step    = inverse ? 32'(cvIf.rate[p]) : 32'h0000_0001;

    // Base level only: boost never moves the curve ratio
    assign cvIf.bucket[p] = ocp_bucket_t'({2'b00, curX100 >= thrX2}) +
                            ocp_bucket_t'({2'b00, curX100 >= thrX5}) +
                            ocp_bucket_t'({2'b00, curX100 >= thrX10}) +
                            ocp_bucket_t'({2'b00, curX100 >= thrX20}); // [R26] [R19]
    assign faultVec[p] = fault;

    always_comb begin
      next_st      = st[p];
      next_pd      = pdCnt;
      next_dd      = ddCnt;
      next_tmr     = tmr;
      next_trip[p] = trip[p];
      if (!enable || blockAct) begin
        next_st      = OCP_IDLE; // [R04] [R25]
        next_pd      = '0;
        next_tmr     = '0;
        next_trip[p] = 1'b0;
      end else begin
        unique case (st[p])
          OCP_IDLE: begin
            next_pd  = '0;
            next_tmr = '0;
            if (fault) next_st = OCP_CONFIRM;
          end
          OCP_CONFIRM: begin
            if (!fault) begin
              next_st = OCP_IDLE;
            end else if (pdCnt >= pickDly) begin
              next_st = OCP_PICKED; // [R23]
            end else if (tick) begin
              next_pd = pdCnt + 1'b1; // [R10]
            end
          end
          OCP_PICKED: begin
            next_dd = '0;
            if (below) begin
              next_st      = trip[p] ? OCP_IDLE : OCP_HOLD;
              next_trip[p] = 1'b0; // [R24]
            end else begin
              if (tick && !expired) next_tmr = tmr + step; // [R26] [R09]
              if (fault && expired) next_trip[p] = 1'b1;   // [R24] [R06]
            end
          end
          OCP_HOLD: begin
            if (!below) begin
              next_st = OCP_PICKED;
            end else if (ddCnt >= dropLim) begin
              next_st = OCP_IDLE; // [R11]
            end else if (tick) begin
              next_dd = ddCnt + 1'b1;
            end
          end
        endcase
      end
      next_pick[p] = next_st[1];
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        st[p]            <= OCP_IDLE;
        pdCnt            <= '0;
        ddCnt            <= '0;
        tmr              <= '0;
        trip[p]          <= 1'b0;
        pickup[p]        <= 1'b0;
        pickupBlocked[p] <= 1'b0;
      end else begin
        st[p]            <= next_st;
        pdCnt            <= next_pd;
        ddCnt            <= next_dd;
        tmr              <= next_tmr;
        trip[p]          <= next_trip[p];       // [R03]
        pickup[p]        <= next_pick[p];       // [R03]
        pickupBlocked[p] <= blockAct && fault;  // [R25]
      end
    end
  end

  // ******
  // Event counters
  // ******
  wire [`OCP_NCNT-1:0] evt = {
    clbStart,                                  // [R22]
    next_pick[2] && !pickup[2],                // [R21]
    next_pick[1] && !pickup[1],
    next_pick[0] && !pickup[0],
    (|next_trip) && !(|trip),                  // [R20]
    (|next_pick) && !(|pickup)};               // [R20]

  for (genvar c = 0; c < `OCP_NCNT; c++) begin : g_cnt
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt[c] <= '0;
      end else if (cntClr) begin
        cnt[c] <= {15'h0000, evt[c]};
      end else if (evt[c]) begin
        cnt[c] <= cnt[c] + 1'b1;
      end
    end
  end

  assign statusWord = {21'h000000, |faultVec, clbAct, pickupBlocked, trip, pickup};

endmodule : ocp_phase_overcurrent
`default_nettype wire

// ---- ocp_defines.svh ----
// Purpose: Shared constants of the phase overcurrent element
// Assumes: 200 MHz clock, 1 ms timer tick
// Notes:   Word indices on AXI4-Lite, one word per register
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define OCP_CLK_NS      5
`define OCP_TICK_NS     1000000
`define OCP_TICK_CYC    (`OCP_TICK_NS / `OCP_CLK_NS)
`define OCP_MS_PER_S    22'd1000
`define OCP_MS_PER_10MS 17'd10

// ****************************************
// Register map
// ****************************************
`define OCP_NCFG        10
`define OCP_R_CTRL      0
`define OCP_R_THR       1
`define OCP_R_TRIPDLY   2
`define OCP_R_PICKDLY   3
`define OCP_R_DROPDLY   4
`define OCP_R_RATIO     5
`define OCP_R_TMS       6
`define OCP_R_CLBLVL    7
`define OCP_R_CLBDUR    8
`define OCP_R_CLBIDLE   9
`define OCP_A_STATUS    6'h0a
`define OCP_A_CNTCLR    6'h0b
`define OCP_A_CNT0      6'h0c
`define OCP_NCNT        6

// ****************************************
// Fields and reset values
// ****************************************
`define OCP_F_EN        0
`define OCP_F_MODE      7:4
`define OCP_F_INRUSH    9:8
`define OCP_F_BLOCK     14:12
`define OCP_F_CLBEN     16
`define OCP_RV_CTRL     32'h0000_0010
`define OCP_RV_THR      32'h0000_0064
`define OCP_RV_TRIPDLY  32'h0000_0032
`define OCP_RV_PICKDLY  32'h0000_0005
`define OCP_RV_DROPDLY  32'h0000_0014
`define OCP_RV_RATIO    32'h0000_005f
`define OCP_RV_TMS      32'h0000_0005
`define OCP_RV_CLBLVL   32'h0000_0096
`define OCP_RV_CLBDUR   32'h0000_003c
`define OCP_RV_CLBIDLE  32'h0000_000a
`define OCP_MK_CTRL     32'h0001_73f1
`define OCP_UNITY       10'h064
`define OCP_CLB_MIN     16'h0005
`define OCP_TMS_SHIFT   24
`define OCP_NBUCKET     5
`define OCP_RESP_OK     2'h0
`define OCP_RESP_ERR    2'h2

`endif

// ---- ocp_pkg.sv ----
// Purpose: Types of the phase overcurrent element
// Assumes: Nothing
// Notes:   Mode codes are the CTRL mode field values
package ocp_pkg;
  typedef enum logic [3:0] {
    OCP_INSTANT, OCP_FIXED_DELAY, OCP_IEC_NI, OCP_IEC_VI, OCP_IEC_EI,
    OCP_IEC_LTI, OCP_IEEE_MI, OCP_IEEE_VI, OCP_IEEE_EI, OCP_RI_CURVE
  } ocp_mode_e;
  typedef enum logic [1:0] {
    OCP_IDLE    = 2'b00,
    OCP_CONFIRM = 2'b01,
    OCP_PICKED  = 2'b11,
    OCP_HOLD    = 2'b10
  } ocp_state_e;
  typedef logic [19:0] ocp_rate_t;
  typedef logic [2:0]  ocp_bucket_t;
endpackage : ocp_pkg

// ---- ocp_curve_if.sv ----
// Purpose: Curve lookup carrier between element and rate table
// Assumes: Three phases
// Notes:   Rate follows curve and bucket by one clock
`timescale 1ns/1ps
`default_nettype none
interface ocp_curve_if;
  import ocp_pkg::*;
  logic [2:0]  curve;
  ocp_bucket_t bucket [3];
  ocp_rate_t   rate   [3];
  modport lookup (input curve, input bucket, output rate);
  modport user   (output curve, output bucket, input rate);
endinterface : ocp_curve_if
`default_nettype wire

// ---- ocp_curve_rom.sv ----
// Purpose: Inverse curve integration rate table, registered read
// Assumes: Rate is 2^24 / trip time in ms at unity multiplier
// Notes:   Buckets are ratio 1.1, 2, 5, 10, 20 times pickup
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defines.svh"
module ocp_curve_rom
  import ocp_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  ocp_curve_if.lookup cv
);
  localparam int NB = `OCP_NBUCKET;
  localparam ocp_rate_t TBL [8*NB] = '{
    20'd229,  20'd1673, 20'd3920,  20'd5647,  20'd7401,
    20'd124,  20'd1243, 20'd4971,  20'd11185, 20'd23613,
    20'd44,   20'd629,  20'd5034,  20'd20764, 20'd83677,
    20'd14,   20'd140,  20'd559,   20'd1259,  20'd2656,
    20'd619,  20'd4412, 20'd9939,  20'd13900, 20'd17698,
    20'd179,  20'd2387, 20'd12827, 20'd24350, 20'd31069,
    20'd125,  20'd1762, 20'd12935, 20'd41273, 20'd87200,
    20'd2088, 20'd3708, 20'd4896,  20'd5291,  20'd5490
  };

  for (genvar p = 0; p < 3; p++) begin : g_ph
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cv.rate[p] <= '0;
      end else begin
        cv.rate[p] <= TBL[int'(cv.curve) * NB + int'(cv.bucket[p])];
      end
    end
  end
endmodule : ocp_curve_rom
`default_nettype wire

// ---- ocp_phase_overcurrent_asserts.sv ----
// Purpose: Port assertions
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module ocp_phase_overcurrent_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [2:0] pickup,
  input wire logic [2:0] trip,
  input wire logic [2:0] pickupBlocked,
  input wire logic       coldLoadActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ******
  // Assertions
  // ******
  a_trip_needs_pickup: assert property ((trip & ~pickup) == 3'h0)
    else $error("trip without pickup");
  a_blocked_no_pickup: assert property ((pickupBlocked & (pickup | trip)) == 3'h0)
    else $error("pickup or trip while blocked");
  a_trip_after_pickup: assert property ((trip & ~$past(trip) & ~$past(pickup)) == 3'h0)
    else $error("trip rose without earlier pickup");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_waits: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  a_read_waits: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  c_trip: cover property ($rose(trip[2]));
  c_block: cover property (pickupBlocked != 3'h0);
  c_boost: cover property ($rose(coldLoadActive));
endmodule : ocp_phase_overcurrent_asserts
bind ocp_phase_overcurrent ocp_phase_overcurrent_asserts ocp_asserts_inst (
  .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pickup, .trip,
  .pickupBlocked, .coldLoadActive);
`default_nettype wire

// ---- ocp_front_end.sv ----
// Purpose: Current front end and breaker model
// Assumes: Breaker opens two clocks after a trip
// Notes:   Open phase reads zero until reclosed
`timescale 1ns/1ps
`default_nettype none
module ocp_front_end (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] demand [3],
  input  wire logic [2:0]  trip,
  input  wire logic        reclose,
  output logic      [15:0] iA,
  output logic      [15:0] iB,
  output logic      [15:0] iC
);
  logic [2:0] seen;
  logic [2:0] brkOpen;
  always_ff @(posedge clk) begin
    seen    <= rst_n ? trip : 3'h0;
    brkOpen <= (!rst_n || reclose) ? 3'h0 : (brkOpen | (seen & trip));
  end
  assign iA = brkOpen[0] ? 16'h0000 : demand[0];
  assign iB = brkOpen[1] ? 16'h0000 : demand[1];
  assign iC = brkOpen[2] ? 16'h0000 : demand[2];
endmodule : ocp_front_end
`default_nettype wire

// ---- ocp_phase_overcurrent_tb_top.sv ----
// Purpose: Self-checking bench
// Assumes: 1 ms tick of 20 clocks
// Notes:   Seeded random data
`timescale 1ns/1ps
`default_nettype none
`include "ocp_defines.svh"
module ocp_phase_overcurrent_tb_top;
  localparam int TICK = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic [15:0] demand [3] = '{default: 16'h0};
  logic [1:0]  inrushDetect = 2'h0;
  logic [3:0]  blockVariable = 4'h0;
  logic        coldLoadInput = 1'b0;
  logic        reclose = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clbAct;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] iA, iB, iC;
  logic [2:0]  pickup, trip, pickupBlocked;
  int          err_total = 0, compares = 0, cyc = 0, n, thr;
  logic [31:0] rv [10] = '{`OCP_RV_CTRL, `OCP_RV_THR, `OCP_RV_TRIPDLY, `OCP_RV_PICKDLY,
    `OCP_RV_DROPDLY, `OCP_RV_RATIO, `OCP_RV_TMS, `OCP_RV_CLBLVL, `OCP_RV_CLBDUR, `OCP_RV_CLBIDLE};
  ocp_phase_overcurrent #(.TICK_CYCLES(TICK)) ocp_phase_overcurrent_inst (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .phaseACurrent(iA),
    .phaseBCurrent(iB), .phaseCCurrent(iC), .inrushDetect, .blockVariable,
    .coldLoadInput, .pickup, .trip, .pickupBlocked, .coldLoadActive(clbAct));
  ocp_front_end ocp_front_end_inst (.clk, .rst_n, .demand, .trip, .reclose, .iA, .iB, .iC);
  always #2.5 clk = ~clk;
  // ******
  // Helpers
  // ******
  function automatic logic faultExp(input int cur, input int th, input int lvl);
    return cur * 100 > th * lvl;
  endfunction : faultExp
  function automatic logic [2:0] outSel(input int w);
    return w == 0 ? pickup : w == 1 ? trip : w == 2 ? pickupBlocked : {2'h0, clbAct};
  endfunction : outSel
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask : rdc
  task automatic waitOut(input int w, input logic [2:0] exp, input int lim);
    n = 0;
    while (outSel(w) !== exp && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : waitOut
  task automatic settle();
    demand <= '{default: 16'h0};
    repeat (4) @(posedge clk);
    reclose <= 1'b1;
    @(posedge clk);
    reclose <= 1'b0;
    @(posedge clk);
  endtask : settle
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ******
  // Scenarios
  // ******
  initial begin
    void'($urandom(32'h842f7b56));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rv[i]) rdc(8'(4 * i), rv[i]);
    rdc(8'h48, 32'h0, 2'h2);
    wr(8'h48, $urandom, 2'h2);
    thr = $urandom;
    wr(8'h04, thr);
    rdc(8'h04, thr & 32'hfff);
    wr(8'h00, 32'h11);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'd100);
    wr(8'h2c, 32'h0);
    demand[0] <= 16'd200;
    waitOut(0, 3'b001, 9);
    chk(n, 3);
    waitOut(1, 3'b001, 9);
    chk(n, 1);
    waitOut(0, 3'b000, 9);
    chk(32'(n <= 5), 1);
    rdc(8'h30, 32'h1);
    rdc(8'h34, 32'h1);
    rdc(8'h38, 32'h1);
    rdc(8'h3c, 32'h0);
    settle();
    for (int ph = 0; ph < 3; ph++) begin
      thr = 5 + $urandom_range(2995);
      wr(8'h04, thr);
      demand[ph] <= 16'(thr);
      repeat (6) @(posedge clk);
      chk(32'(pickup), 32'(faultExp(thr, thr, 100)) << ph);
      demand[ph] <= 16'(thr + 1);
      waitOut(0, 3'(1 << ph), 9);
      chk(n, 3);
      settle();
    end
    wr(8'h04, 32'd100);
    wr(8'h08, 32'h1);
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, 32'(m << 4) | 32'h1);
      demand[1] <= 16'd300;
      waitOut(0, 3'b010, 9);
      waitOut(1, 3'b010, 300);
      chk(32'(n > 180 && n < 230), 1);
      settle();
    end
    for (int m = 2; m < 10; m++) begin
      wr(8'h00, 32'(m << 4) | 32'h1);
      demand[2] <= 16'd2000;
      waitOut(0, 3'b100, 9);
      waitOut(1, 3'b100, 8000);
      chk(32'(n > 40 && n < 8000), 1);
      settle();
    end
    wr(8'h08, 32'd100);
    for (int k = 0; k < 6; k++) begin
      wr(8'h00, 32'h11 | (k < 4 ? 32'(k + 1) << 12 : 32'(k - 3) << 8));
      demand[0] <= 16'd300;
      waitOut(0, 3'b001, 9);
      if (k < 4) blockVariable <= 4'(1 << k);
      else inrushDetect <= 2'(1 << (k - 4));
      waitOut(2, 3'b001, 4);
      chk(32'(pickup), 32'h0);
      blockVariable <= 4'h0;
      inrushDetect <= 2'h0;
      waitOut(0, 3'b001, 9);
      chk(32'(n <= 5), 1);
      settle();
    end
    demand[0] <= 16'd300;
    wr(8'h00, 32'h10);
    repeat (20) @(posedge clk);
    chk(32'(pickup | trip), 32'h0);
    settle();
    wr(8'h00, 32'h11);
    wr(8'h10, 32'h1);
    demand[0] <= 16'd200;
    waitOut(0, 3'b001, 9);
    demand[0] <= 16'd97;
    repeat (300) @(posedge clk);
    chk(32'(pickup), 32'h1);
    demand[0] <= 16'd94;
    waitOut(0, 3'b000, 300);
    chk(32'(n > 180 && n < 230), 1);
    settle();
    wr(8'h00, 32'h10011);
    wr(8'h20, 32'h1);
    coldLoadInput <= 1'b1;
    waitOut(3, 3'b001, 9);
    chk(32'(n <= 6), 1);
    demand[0] <= 16'd140;
    repeat (10) @(posedge clk);
    chk(32'(pickup), 32'(faultExp(140, 100, 150)));
    demand[0] <= 16'd160;
    waitOut(0, 3'b001, 9);
    chk(n, 3);
    rdc(8'h28, 32'h601);
    rdc(8'h44, 32'h1);
    waitOut(3, 3'b000, 21000);
    chk(32'(n > 19000 && n < 21000), 1);
    report_and_stop();
  end
endmodule : ocp_phase_overcurrent_tb_top
`default_nettype wire
